// ---- rtl/efge_supp_filter.sv ----
// Purpose: Suppression-delay filter for one error sensor
// Assumes: Sensor level already in the system clock domain
// Notes: One delay step is one system clock cycle
`timescale 1ns/10ps
module efge_supp_filter #(
  parameter int CW = efge_pkg::SUPP_W
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Sensor and delay setting
  input wire logic i_raw,
  input wire logic [CW-1:0] i_delay,
  // Filtered hit
  output logic o_hit
);
  if (CW < 1 || CW > 16) begin : g_bad_cw
    $error("efge_supp_filter: counter width out of range");
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic hit_nxt;
  logic at_top;

  // Saturate so a long fault never wraps back to quiet
  assign at_top = (cnt_r == {CW{1'b1}});
  assign cnt_nxt = !i_raw ? '0 : (at_top ? cnt_r : cnt_r + 1'b1);
  assign hit_nxt = i_raw && (cnt_r >= i_delay);

  // Counter and registered hit
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      cnt_r <= '0;
      o_hit <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      o_hit <= hit_nxt;
    end
  end

  chk_filter_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !i_raw |=> !o_hit) else $error("filter hit without sensor");
endmodule : efge_supp_filter

// ---- rtl/efge_top.sv ----
// Purpose: Error flag latching and general-purpose pin port with serial access
// Assumes: Serial pins and pin inputs are asynchronous; sensors are on i_clk_sys
// Notes: Serial clock must be well below a quarter of i_clk_sys
`timescale 1ns/10ps
module efge_top #(
  parameter int NPIN = efge_pkg::NPIN
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Serial port pins
  input wire logic i_spi_cs_b,
  input wire logic i_spi_sclk,
  input wire logic i_spi_sdi,
  output logic o_spi_sdo,
  output logic o_spi_sdo_oe,
  // General-purpose pins
  input wire logic [NPIN-1:0] i_gpio_in,
  output logic [NPIN-1:0] o_gpio_out,
  output logic [NPIN-1:0] o_gpio_oe,
  // Analog status
  input wire logic [efge_pkg::NSENSE-1:0] i_err_sense,
  input wire logic i_checksum_fail,
  input wire logic i_buf_active,
  input wire logic i_osc_clk,
  // Analog control
  output logic [7:0] o_gain,
  output logic [7:0] o_buftim,
  output logic [7:0] o_test_switch,
  output logic o_buf_trigger,
  output logic o_sync_in,
  output logic o_checksum_mode,
  output logic [efge_pkg::NFLAG-1:0] o_err_flags,
  output logic o_err_any
);
  if (NPIN != 7) begin : g_bad_npin
    $error("efge_top: pin routing is built for seven pins");
  end

  localparam int NS = NPIN + 3;
  localparam int NF = efge_pkg::NFLAG;

  // Synchroniser chain: cs, sclk, sdi, pins
  logic [NS-1:0] meta_r;
  logic [NS-1:0] sync_r;
  logic cs_prev_r;
  logic sclk_prev_r;
  logic buft_prev_r;
  wire cs_s = sync_r[0];
  wire sclk_s = sync_r[1];
  wire sdi_s = sync_r[2];
  wire [NPIN-1:0] gpio_s = sync_r[NS-1:3];

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      meta_r <= {NS{1'b1}};
      sync_r <= {NS{1'b1}};
    end else begin
      meta_r <= {i_gpio_in, i_spi_sdi, i_spi_sclk, i_spi_cs_b};
      sync_r <= meta_r;
    end
  end

  // Edge history on the second stage only
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      cs_prev_r <= 1'b1;
      sclk_prev_r <= 1'b1;
      buft_prev_r <= 1'b1; // Matches the synchroniser reset level, so no false edge
    end else begin
      cs_prev_r <= cs_s;
      sclk_prev_r <= sclk_s;
      buft_prev_r <= gpio_s[efge_pkg::PIN_BUFFER_TRIGGER_INPUT_FUNCTION];
    end
  end

  wire sclk_fall = sclk_prev_r && !sclk_s;
  wire sclk_rise = !sclk_prev_r && sclk_s;
  wire cs_rise = !cs_prev_r && cs_s;

  // Registers
  logic [7:0] gain_r;
  logic [7:0] cphase_r;
  logic [7:0] buftim_r;
  logic [7:0] tsw_r;
  logic [7:0] dir_r;
  logic [7:0] ecs_mode_r;
  logic [7:0] pinval_r;
  logic [7:0] cfg_r;
  logic [7:0] sfr_r;
  logic [NF-1:0] flag_r;

  // Serial engine state
  efge_pkg::efge_spi_st_t st_r;
  efge_pkg::efge_spi_st_t st_nxt;
  logic [4:0] bitcnt_r;
  logic [7:0] sh_r;
  logic [7:0] cmd_r;
  logic [7:0] tx_r;
  logic [2:0] ecs_pin_r;

  wire chk_mode = cfg_r[efge_pkg::CFG_CHK_BIT];
  wire ltd = cfg_r[efge_pkg::CFG_LTD_BIT];
  wire [7:0] byte_in = {sh_r[6:0], sdi_s};
  wire [4:0] frame_last = chk_mode ? efge_pkg::LAST_CHK : efge_pkg::LAST_DATA;
  wire in_frame = !cs_s && (st_r == efge_pkg::ST_SHIFT || st_r == efge_pkg::ST_RDOUT);
  wire fall_ok = in_frame && sclk_fall;
  wire cmd_done = fall_ok && (bitcnt_r == efge_pkg::LAST_CMD);
  wire data_done = fall_ok && (bitcnt_r == efge_pkg::LAST_DATA);
  wire frame_done = fall_ok && (bitcnt_r == frame_last);

  // Command decode at the end of the first byte
  wire [1:0] op = byte_in[7:6];
  wire is_read = cmd_done && op == efge_pkg::CMD_READ && byte_in[5:4] == 2'h0;
  wire is_dcs = cmd_done && op == efge_pkg::CMD_DCS && !byte_in[3];
  wire [2:0] dcs_pin = byte_in[2:0];
  wire dcs_ok = is_dcs && (dcs_pin < 3'(NPIN)) && ecs_mode_r[dcs_pin];
  wire dcs_cp = cphase_r[dcs_pin];
  wire trig_cmd = cmd_done && byte_in[efge_pkg::CMD_TRIG_BIT]
    && (op == efge_pkg::CMD_WRITE || op == efge_pkg::CMD_DCS);
  wire wr_en = data_done && cmd_r[7:6] == efge_pkg::CMD_WRITE && !cmd_r[4];
  wire [3:0] waddr = cmd_r[3:0];
  wire dcs_single = is_dcs && !dcs_ok;

  // Read data selection
  wire [3:0] raddr = byte_in[3:0];
  wire [7:0] rd_data =
    raddr == efge_pkg::A_GAIN ? gain_r :
    raddr == efge_pkg::A_CPHASE ? cphase_r :
    raddr == efge_pkg::A_BUFTIM ? buftim_r :
    raddr == efge_pkg::A_ERR ? 8'(flag_r) :
    raddr == efge_pkg::A_TSW ? tsw_r :
    raddr == efge_pkg::A_DIR ? dir_r :
    raddr == efge_pkg::A_ECS ? ecs_mode_r :
    raddr == efge_pkg::A_PINVAL ? 8'(gpio_s) :
    raddr == efge_pkg::A_CFG ? cfg_r :
    raddr == efge_pkg::A_SFR ? sfr_r : 8'h00;

  // Next state; a high chip select always wins
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      efge_pkg::ST_SHIFT: begin
        if (is_read) begin
          st_nxt = efge_pkg::ST_RDOUT;
        end else if (dcs_ok) begin
          st_nxt = dcs_cp ? efge_pkg::ST_EACT : efge_pkg::ST_EWAIT;
        end
      end
      efge_pkg::ST_RDOUT: begin
        if (frame_done) begin
          st_nxt = efge_pkg::ST_SHIFT;
        end
      end
      efge_pkg::ST_EWAIT: begin
        if (sclk_rise) begin
          st_nxt = efge_pkg::ST_EACT;
        end
      end
      efge_pkg::ST_EACT: st_nxt = efge_pkg::ST_EACT;
      default: st_nxt = efge_pkg::ST_SHIFT;
    endcase
    if (cs_s) begin
      st_nxt = efge_pkg::ST_SHIFT;
    end
  end

  // Serial shift, count and state
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      st_r <= efge_pkg::ST_SHIFT;
      bitcnt_r <= 5'h00;
      sh_r <= 8'h00;
      cmd_r <= 8'h00;
      ecs_pin_r <= 3'h0;
    end else begin
      st_r <= st_nxt;
      if (cs_s) begin
        bitcnt_r <= 5'h00;
      end else if (frame_done || dcs_single) begin
        bitcnt_r <= 5'h00; // Chained commands restart here
      end else if (fall_ok) begin
        bitcnt_r <= bitcnt_r + 5'h01;
      end
      if (fall_ok) begin
        sh_r <= byte_in;
      end
      if (cmd_done) begin
        cmd_r <= byte_in;
      end
      if (dcs_ok) begin
        ecs_pin_r <= dcs_pin;
      end
    end
  end

  // Read data out: data changes on rising serial clock
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      tx_r <= 8'h00;
      o_spi_sdo <= 1'b0;
      o_spi_sdo_oe <= 1'b0;
    end else begin
      if (is_read) begin
        tx_r <= rd_data;
      end else if (st_r == efge_pkg::ST_RDOUT && sclk_rise && !cs_s) begin
        tx_r <= {tx_r[6:0], 1'b0};
        o_spi_sdo <= tx_r[7];
        o_spi_sdo_oe <= 1'b1;
      end
      if (cs_s || st_r != efge_pkg::ST_RDOUT) begin
        o_spi_sdo_oe <= 1'b0;
      end
    end
  end

  // Register writes; error register write clears the ones written
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      gain_r <= efge_pkg::GAIN_RST;
      cphase_r <= efge_pkg::ZERO_RST;
      buftim_r <= efge_pkg::BUFTIM_RST;
      tsw_r <= efge_pkg::ZERO_RST;
      dir_r <= efge_pkg::ZERO_RST;
      ecs_mode_r <= efge_pkg::ZERO_RST;
      pinval_r <= efge_pkg::ZERO_RST;
      cfg_r <= efge_pkg::ZERO_RST;
      sfr_r <= efge_pkg::ZERO_RST;
    end else if (wr_en) begin
      case (waddr)
        efge_pkg::A_GAIN: gain_r <= byte_in;
        efge_pkg::A_CPHASE: cphase_r <= byte_in;
        efge_pkg::A_BUFTIM: buftim_r <= byte_in;
        efge_pkg::A_TSW: tsw_r <= byte_in;
        efge_pkg::A_DIR: dir_r <= byte_in;
        efge_pkg::A_ECS: ecs_mode_r <= byte_in;
        efge_pkg::A_PINVAL: pinval_r <= byte_in;
        efge_pkg::A_CFG: cfg_r <= byte_in;
        efge_pkg::A_SFR: sfr_r <= byte_in;
        default: ;
      endcase
    end
  end

  // Sensor gating and filtering; buffer time masks every sensor
  wire [efge_pkg::NSENSE-1:0] sense_gated = i_err_sense & {efge_pkg::NSENSE{!i_buf_active}};
  logic [efge_pkg::NSENSE-1:0] hit;
  for (genvar g = 0; g < efge_pkg::NSENSE; g++) begin : g_filt
    efge_supp_filter #(.CW(efge_pkg::SUPP_W)) u_filt (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_raw(sense_gated[g]),
      .i_delay(cfg_r[efge_pkg::CFG_SUPP_LSB +: efge_pkg::SUPP_W]),
      .o_hit(hit[g])
    );
  end

  // Flag update: a new event beats a clear in the same cycle
  wire chk_ev = i_checksum_fail && chk_mode;
  wire [NF-1:0] ev = {chk_ev, hit};
  wire [NF-1:0] clr = (wr_en && waddr == efge_pkg::A_ERR) ? byte_in[NF-1:0] : '0;
  wire [NF-1:0] flag_nxt = ltd ? ev : (ev | (flag_r & ~clr));

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      flag_r <= '0;
      o_err_any <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      o_err_any <= |flag_r;
    end
  end

  // Pin value selection: select mode over special function over stored value
  wire ecs_act = (st_r == efge_pkg::ST_EACT) && !cs_s;
  wire [NPIN-1:0] ecs_lvl = ~(ecs_act ? NPIN'(1) << ecs_pin_r : NPIN'(0));
  wire [NPIN-1:0] sf_sel = {sfr_r[efge_pkg::SF_OSCILLATOR_OUTPUT_FUNCTION], sfr_r[efge_pkg::SF_BUFFER_ACTIVE_OUTPUT_FUNCTION], 1'b0,
    sfr_r[efge_pkg::SF_ERROR_FLAG_OUTPUT_FUNCTION], sfr_r[efge_pkg::SF_EXT_MUX_ADDR_BIT2:efge_pkg::SF_EXT_MUX_ADDR_BIT0]};
  wire [NPIN-1:0] sf_val = {i_osc_clk, i_buf_active, 1'b0, o_err_any, gain_r[2:0]};
  wire [NPIN-1:0] ecs_m = ecs_mode_r[NPIN-1:0];
  wire [NPIN-1:0] pin_nxt = (ecs_m & ecs_lvl) | (~ecs_m & sf_sel & sf_val)
    | (~ecs_m & ~sf_sel & pinval_r[NPIN-1:0]);
  wire buft_pin = sfr_r[efge_pkg::SF_BUFFER_TRIGGER_INPUT_FUNCTION] && gpio_s[efge_pkg::PIN_BUFFER_TRIGGER_INPUT_FUNCTION] && !buft_prev_r;

  // Registered pin drive and control outputs
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_gpio_out <= '0;
      o_gpio_oe <= '0;
      o_buf_trigger <= 1'b0;
      o_sync_in <= 1'b0;
    end else begin
      o_gpio_out <= pin_nxt;
      o_gpio_oe <= dir_r[NPIN-1:0];
      o_buf_trigger <= trig_cmd || buft_pin;
      o_sync_in <= sfr_r[efge_pkg::SF_SYNC_INPUT_FUNCTION] && gpio_s[efge_pkg::PIN_SYNC];
    end
  end

  // Plain register copies; the direction sequence is the host's duty
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_gain <= efge_pkg::GAIN_RST;
      o_buftim <= efge_pkg::BUFTIM_RST;
      o_test_switch <= efge_pkg::ZERO_RST;
      o_checksum_mode <= 1'b0;
      o_err_flags <= '0;
    end else begin
      o_gain <= gain_r;
      o_buftim <= buftim_r;
      o_test_switch <= tsw_r;
      o_checksum_mode <= chk_mode;
      o_err_flags <= flag_r;
    end
  end

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  chk_flag_held: assert property (!ltd && flag_r[0] && clr[0] == 1'b0 |=> flag_r[0])
    else $error("latched flag dropped without clear");
  chk_follow_live: assert property (ltd |=> flag_r == $past(ev))
    else $error("unlatched flag not following event");
  chk_err_or_pin: assert property (##1 o_err_any == $past(|flag_r))
    else $error("error output differs from OR of flags");
  chk_buf_masks: assert property (i_buf_active [*2] |=> hit == '0)
    else $error("sensor hit during buffer time");
  chk_crc_gate: assert property (!chk_mode && !flag_r[efge_pkg::FLG_CHK] |=> !flag_r[efge_pkg::FLG_CHK])
    else $error("checksum flag set with mode off");
  chk_reset_inputs: assert property (@(posedge i_clk_sys) disable iff (1'b0) !i_rst_b |=> o_gpio_oe == '0)
    else $error("pin driven after reset");
  chk_dir_drive: assert property (##1 o_gpio_oe == $past(dir_r[NPIN-1:0]))
    else $error("pin enable not from direction register");
  chk_mux_follow: assert property (sfr_r[0] && !ecs_mode_r[0] |=> o_gpio_out[0] == $past(gain_r[0]))
    else $error("mux pin not following gain register");
  chk_ecs_phase: assert property (st_r == efge_pkg::ST_EWAIT && !cs_s && sclk_rise |=> st_r == efge_pkg::ST_EACT)
    else $error("select not asserted after rising edge");
  chk_ecs_quiet: assert property (st_r == efge_pkg::ST_EACT |=> !o_spi_sdo_oe)
    else $error("data output driven during extended select");
  chk_ecs_release: assert property (cs_rise |=> ##1 (o_gpio_out | ~ecs_m) == '1)
    else $error("select pin not released on chip select high");

  cov_write: cover property (wr_en);
  cov_read: cover property (is_read ##[1:400] o_spi_sdo_oe);
  cov_ecs: cover property (ecs_act);
  cov_flag: cover property (|flag_r);
endmodule : efge_top

// ---- shared/efge_pkg.sv ----
// Purpose: Shared constants for the error flag and general-purpose pin block
// Assumes: Eight-bit registers behind a four-bit register pointer
// Notes: Field positions and reset values live here; efge_top still slices the command byte and gain_r[2:0] inline
package efge_pkg;
  // Port and flag geometry
  localparam int NPIN = 7;
  localparam int NFLAG = 5;
  localparam int NSENSE = 4;
  localparam int SUPP_W = 4;

  // Register pointers
  localparam logic [3:0] A_GAIN = 4'h0;
  localparam logic [3:0] A_CPHASE = 4'h2;
  localparam logic [3:0] A_BUFTIM = 4'h3;
  localparam logic [3:0] A_ERR = 4'h4;
  localparam logic [3:0] A_TSW = 4'h6;
  localparam logic [3:0] A_DIR = 4'h8;
  localparam logic [3:0] A_ECS = 4'h9;
  localparam logic [3:0] A_PINVAL = 4'ha;
  localparam logic [3:0] A_CFG = 4'hb;
  localparam logic [3:0] A_SFR = 4'hc;

  // Reset values
  localparam logic [7:0] GAIN_RST = 8'h00;
  localparam logic [7:0] BUFTIM_RST = 8'h19;
  localparam logic [7:0] ZERO_RST = 8'h00;

  // Configuration register fields
  localparam int CFG_SUPP_LSB = 0;
  localparam int CFG_CHK_BIT = 6;
  localparam int CFG_LTD_BIT = 7;

  // Error flag positions
  localparam int FLG_CLAMP = 0;
  localparam int FLG_IOV = 1;
  localparam int FLG_GAIN = 2;
  localparam int FLG_OUT = 3;
  localparam int FLG_CHK = 4;

  // Special-function select bits; bit n routes to pin n, bit 7 to pin 6
  localparam int SF_EXT_MUX_ADDR_BIT0 = 0;
  localparam int SF_EXT_MUX_ADDR_BIT1 = 1;
  localparam int SF_EXT_MUX_ADDR_BIT2 = 2;
  localparam int SF_ERROR_FLAG_OUTPUT_FUNCTION = 3;
  localparam int SF_BUFFER_TRIGGER_INPUT_FUNCTION = 4;
  localparam int SF_BUFFER_ACTIVE_OUTPUT_FUNCTION = 5;
  localparam int SF_SYNC_INPUT_FUNCTION = 6;
  localparam int SF_OSCILLATOR_OUTPUT_FUNCTION = 7;
  localparam int PIN_BUFFER_TRIGGER_INPUT_FUNCTION = 4;
  localparam int PIN_SYNC = 6;

  // Command byte fields
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ = 2'h2;
  localparam logic [1:0] CMD_DCS = 2'h3;
  localparam int CMD_TRIG_BIT = 5;

  // Falling-edge counts at byte ends
  localparam logic [4:0] LAST_CMD = 5'h07;
  localparam logic [4:0] LAST_DATA = 5'h0f;
  localparam logic [4:0] LAST_CHK = 5'h17;

  // Serial engine states
  typedef enum logic [3:0] {
    ST_SHIFT = 4'b0001,
    ST_RDOUT = 4'b0010,
    ST_EWAIT = 4'b0100,
    ST_EACT = 4'b1000
  } efge_spi_st_t;
endpackage : efge_pkg

// ---- sim/efge_spi_host.sv ----
// Purpose: Serial host model driving the block's serial port
// Assumes: Clock idles high; the slave samples on falling edges
// Notes: Half period of four system clocks gives the 800 ns link clock
`timescale 1ns/10ps
module efge_spi_host (
  // Clock
  input wire logic i_clk_sys,
  // Slave data return
  input wire logic i_sdo,
  input wire logic i_sdo_oe,
  // Lines towards the slave
  output logic o_cs_b,
  output logic o_sclk,
  output logic o_sdi
);
  // Released return line sits at the pull-up level
  wire logic sdo_line = i_sdo_oe ? i_sdo : 1'b1;

  // Idle lines at time zero
  initial begin
    o_cs_b = 1'b1;
    o_sclk = 1'b1;
    o_sdi = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : wait_clk

  // One frame MSB first; stop_low keeps select low and clock low at the end
  task automatic frame(input int nbits, input logic [23:0] tx, input bit stop_low, output logic [23:0] rx);
    rx = 24'h0;
    @(posedge i_clk_sys);
    o_cs_b <= 1'b0;
    o_sclk <= 1'b1;
    wait_clk(4);
    for (int i = nbits - 1; i >= 0; i--) begin
      o_sdi <= tx[i];
      wait_clk(4);
      o_sclk <= 1'b0;
      wait_clk(2);
      // Mid-low sample, clear of the edge that ends the read byte
      rx = {rx[22:0], sdo_line};
      wait_clk(2);
      if (i > 0 || !stop_low) o_sclk <= 1'b1;
    end
    if (!stop_low) release_bus();
  endtask : frame

  // Ends the frame; data line flips so a stale bit is never seen
  task automatic release_bus();
    @(posedge i_clk_sys);
    o_sclk <= 1'b1;
    wait_clk(8);
    o_cs_b <= 1'b1;
    o_sdi <= ~o_sdi;
    wait_clk(8);
  endtask : release_bus
endmodule : efge_spi_host

// ---- sim/efge_top_tb_top.sv ----
// Purpose: Self-checking bench for flag latching and pin port
// Assumes: Checksum pulse input is not delay filtered
// Notes: Delay setting 3 used for all flag rows
`timescale 1ns/10ps
module efge_top_tb_top;
  typedef struct packed {logic [3:0] sense; logic [3:0] hold; logic [4:0] flags;} efge_row_t;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [6:0] gpio_in = 7'h00;
  logic [3:0] err_sense = 4'h0;
  logic chk_fail = 1'b0;
  logic buf_act = 1'b0;
  logic osc = 1'b0;
  logic cs_b, sclk, sdi, sdo, sdo_oe, buf_trig, sync_in, chk_mode, err_any;
  logic [6:0] gpio_out, gpio_oe;
  logic [7:0] gain, buftim, tsw;
  logic [4:0] flags;
  logic [23:0] rx;
  int trig_cnt = 0;
  int c;
  int miscompares = 0;
  int cmp_count = 0;
  // Short holds probe the suppression boundary
  efge_row_t rows [7] = '{'{4'h1, 4'h8, 5'h01}, '{4'h2, 4'h8, 5'h02}, '{4'h4, 4'h8, 5'h04},
    '{4'h8, 4'h8, 5'h08}, '{4'h1, 4'h3, 5'h00}, '{4'h2, 4'h4, 5'h02}, '{4'hf, 4'h8, 5'h0f}};

  always #50 clk_sys = ~clk_sys;

  // Trigger is a one-cycle pulse, so count it
  always @(posedge clk_sys) if (buf_trig === 1'b1) trig_cnt <= trig_cnt + 1;

  efge_top efge_top_inst (.i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_spi_cs_b(cs_b), .i_spi_sclk(sclk),
    .i_spi_sdi(sdi), .o_spi_sdo(sdo), .o_spi_sdo_oe(sdo_oe), .i_gpio_in(gpio_in), .o_gpio_out(gpio_out),
    .o_gpio_oe(gpio_oe), .i_err_sense(err_sense), .i_checksum_fail(chk_fail), .i_buf_active(buf_act),
    .i_osc_clk(osc), .o_gain(gain), .o_buftim(buftim), .o_test_switch(tsw), .o_buf_trigger(buf_trig),
    .o_sync_in(sync_in), .o_checksum_mode(chk_mode), .o_err_flags(flags), .o_err_any(err_any));

  efge_spi_host efge_spi_host_inst (.i_clk_sys(clk_sys), .i_sdo(sdo), .i_sdo_oe(sdo_oe), .o_cs_b(cs_b),
    .o_sclk(sclk), .o_sdi(sdi));

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  task automatic wr(input logic [15:0] cmd);
    efge_spi_host_inst.frame(16, {8'h00, cmd}, 1'b0, rx);
  endtask : wr

  // Sensor high for exactly n sampling edges
  task automatic hold_sense(input logic [3:0] s, input int n);
    @(posedge clk_sys);
    err_sense <= s;
    tick(n);
    err_sense <= 4'h0;
    tick(5);
  endtask : hold_sense

  task automatic test_done();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  // Hang guard, well past the expected run length
  initial begin
    tick(60000);
    miscompares++;
    test_done();
  end

  // Main sequence
  initial begin
    tick(8);
    rst_b <= 1'b1;
    tick(4);
    check("oe rst", 24'(gpio_oe), 24'h0);
    check("out rst", 24'(gpio_out), 24'h0);
    check("buftim", 24'(buftim), 24'h19);
    wr(16'h4b03);
    foreach (rows[k]) begin
      hold_sense(rows[k].sense, int'(rows[k].hold));
      check("flags", 24'(flags), 24'(rows[k].flags));
      check("any", 24'(err_any), 24'(|rows[k].flags));
      tick(20);
      check("held", 24'(flags), 24'(rows[k].flags));
      wr(16'h44ff);
      check("cleared", 24'(flags), 24'h0);
    end
    // Flag readback over the serial port
    hold_sense(4'h8, 8);
    efge_spi_host_inst.frame(16, 24'h8400, 1'b0, rx);
    check("read flags", 24'(rx[7:0]), 24'h08);
    wr(16'h44ff);
    // Buffer active masks sensors
    @(posedge clk_sys);
    buf_act <= 1'b1;
    hold_sense(4'h1, 10);
    check("masked", 24'(flags), 24'h0);
    buf_act <= 1'b0;
    // Latch disabled: flag follows the live level
    wr(16'h4b83);
    @(posedge clk_sys);
    err_sense <= 4'h2;
    tick(8);
    check("live", 24'(flags), 24'h02);
    err_sense <= 4'h0;
    tick(5);
    check("live off", 24'(flags), 24'h0);
    // Checksum flag gated by checksum mode
    for (int m = 0; m < 2; m++) begin
      wr(m ? 16'h4b43 : 16'h4b03);
      @(posedge clk_sys);
      chk_fail <= 1'b1;
      @(posedge clk_sys);
      chk_fail <= 1'b0;
      tick(5);
      check("chk flag", 24'(flags), m ? 24'h10 : 24'h0);
    end
    check("chk mode", 24'(chk_mode), 24'h1);
    efge_spi_host_inst.frame(24, 24'h4b0300, 1'b0, rx);
    check("chk off", 24'(chk_mode), 24'h0);
    wr(16'h44ff);
    wr(16'h46a5);
    check("switches", 24'(tsw), 24'ha5);
    // Stored value written before direction
    wr(16'h4a05);
    check("oe still", 24'(gpio_oe), 24'h0);
    wr(16'h480b);
    check("oe", 24'(gpio_oe), 24'h0b);
    check("stored", 24'(gpio_out & gpio_oe), 24'h01);
    wr(16'h4c0b);
    wr(16'h4006);
    check("mux", 24'(gpio_out[1:0]), 24'h2);
    hold_sense(4'h4, 8);
    check("ef pin", 24'(gpio_out[3]), 24'h1);
    wr(16'h44ff);
    check("ef clr", 24'(gpio_out[3]), 24'h0);
    // Oscillator, buffer-active and trigger functions
    wr(16'h4860);
    wr(16'h4cb0);
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk_sys);
      buf_act <= v[0];
      osc <= v[0];
      tick(4);
      check("sf out", 24'(gpio_out[6:5]), v ? 24'h3 : 24'h0);
    end
    c = trig_cnt;
    gpio_in[4] <= 1'b1;
    tick(8);
    check("trig", 24'(trig_cnt - c), 24'h1);
    // Trigger bit in a write command fires the buffer once
    c = trig_cnt;
    wr(16'h6b03);
    check("trig cmd", 24'(trig_cnt - c), 24'h1);
    wr(16'h4c40);
    gpio_in[6] <= 1'b1;
    tick(5);
    check("sync", 24'(sync_in), 24'h1);
    // Extended select on pin 1, direction first
    wr(16'h4802);
    wr(16'h4902);
    wr(16'h4202);
    efge_spi_host_inst.frame(8, 24'hc1, 1'b1, rx);
    tick(6);
    check("ecs cp1", 24'(gpio_out[1]), 24'h0);
    efge_spi_host_inst.frame(16, 24'h40ff, 1'b1, rx);
    check("sdo off", 24'(sdo_oe), 24'h0);
    check("ignored", 24'(gain), 24'h06);
    check("ecs held", 24'(gpio_out[1]), 24'h0);
    efge_spi_host_inst.release_bus();
    check("ecs end", 24'(gpio_out[1]), 24'h1);
    wr(16'h4200);
    efge_spi_host_inst.frame(8, 24'hc1, 1'b1, rx);
    tick(6);
    check("ecs cp0 wait", 24'(gpio_out[1]), 24'h1);
    fork
      efge_spi_host_inst.release_bus();
      begin
        tick(8);
        check("ecs cp0", 24'(gpio_out[1]), 24'h0);
      end
    join
    check("ecs end0", 24'(gpio_out[1]), 24'h1);
    // Mid-run reset returns pins to inputs with zero stored values
    wr(16'h4803);
    wr(16'h4a03);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    tick(8);
    rst_b <= 1'b1;
    tick(4);
    check("oe rst2", 24'(gpio_oe), 24'h0);
    wr(16'h4801);
    check("out rst2", 24'(gpio_out & gpio_oe), 24'h0);
    test_done();
  end
endmodule : efge_top_tb_top
